// ===== inc/rtdseq_pkg.sv
package rtdseq_pkg;
  // Register byte addresses
  localparam logic [7:0]  ADDR_CFG0    = 8'h00;
  localparam logic [7:0]  ADDR_CFG6    = 8'h04;
  localparam logic [7:0]  ADDR_CMD     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  localparam logic [7:0]  ADDR_RES0    = 8'h10;
  localparam logic [7:0]  ADDR_CLKDIV  = 8'h20;
  // Field positions
  localparam int CFG0_DUMMY_BIT  = 15;
  localparam int CFG0_CYCLE_BIT  = 16;
  localparam int CFG0_PORTS_BIT  = 17;
  localparam int CFG6_REVERSE_BIT = 11;
  localparam int CFG6_MAINS_BIT  = 15;
  localparam int CFG6_FACTOR_LSB = 18;
  localparam int CFG6_INVERT_BIT = 30;
  localparam int CFG6_OSC_LSB    = 0;
  // Opcodes written to the command register
  localparam logic [7:0]  OP_TEMP_SINGLE  = 8'h02;
  localparam logic [7:0]  OP_TEMP_RESTART = 8'h03;
  localparam logic [7:0]  OP_CLEAR_INT    = 8'h04;
  // Reset values
  localparam logic [31:0] CFG0_RST   = 32'h0000_0000;
  localparam logic [31:0] CFG6_RST   = 32'h0000_0000;
  localparam logic [7:0]  CLKDIV_RST = 8'h05;
  // Result codes
  localparam logic [31:0] RES_SHORT = 32'h0000_0000;
  localparam logic [31:0] RES_OPEN  = 32'h0fff_ffff;
  // Timing in reference clock ticks (reference clock nominally 4 MHz)
  localparam int REF_MHZ         = 4;
  localparam int CYCLE_SHORT_US  = 128;
  localparam int CYCLE_LONG_US   = 512;
  localparam logic [23:0] CYCLE_SHORT_TK = 24'(CYCLE_SHORT_US * REF_MHZ);
  localparam logic [23:0] CYCLE_LONG_TK  = 24'(CYCLE_LONG_US * REF_MHZ);
  localparam logic [23:0] SHORT_LIMIT_TK = 24'h00_0008;
  // Half mains period in ticks: 10 ms and 8333 us
  localparam int HALF50_US = 10000;
  localparam int HALF60_US = 8333;
  localparam logic [23:0] HALF50_TK = 24'(HALF50_US * REF_MHZ);
  localparam logic [23:0] HALF60_TK = 24'(HALF60_US * REF_MHZ);
  // Oscillator settling delays
  localparam int SETTLE0_US = 480;
  localparam int SETTLE1_US = 1460;
  localparam int SETTLE2_US = 2440;
  localparam int SETTLE3_US = 5140;
  localparam logic [23:0] SETTLE0_TK = 24'(SETTLE0_US * REF_MHZ);
  localparam logic [23:0] SETTLE1_TK = 24'(SETTLE1_US * REF_MHZ);
  localparam logic [23:0] SETTLE2_TK = 24'(SETTLE2_US * REF_MHZ);
  localparam logic [23:0] SETTLE3_TK = 24'(SETTLE3_US * REF_MHZ);
  localparam logic [2:0]  DUMMY_FEW  = 3'h2;
  localparam logic [2:0]  DUMMY_MANY = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_SETTLE = 7'b0000010,
    ST_CHARGE = 7'b0000100,
    ST_DISCH  = 7'b0001000,
    ST_STORE  = 7'b0010000,
    ST_WAIT   = 7'b0100000,
    ST_DONE   = 7'b1000000
  } rtdseq_state_type;
endpackage

// ===== inc/rtdseq_res_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtdseq_res_if;
  logic        wr_en;
  logic [1:0]  wr_idx;
  logic [31:0] wr_data;
  logic [1:0]  rd_idx;
  logic [31:0] rd_data;
  modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ===== verilog/rtdseq_tick.sv
`timescale 1ns/1ps
`default_nettype none
module rtdseq_tick (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] div,
  output var  logic       tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } rtdseq_tick_type;
  rtdseq_tick_type st_ff, nxt_st;
  // One-cycle reference tick every div+1 pclk cycles
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= div) begin
      nxt_st.cnt = 8'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
endmodule
`default_nettype wire

// ===== verilog/rtdseq_resmem.sv
`timescale 1ns/1ps
`default_nettype none
module rtdseq_resmem (
  input  wire logic   pclk,
  input  wire logic   presetn,
  rtdseq_res_if.mem   rif
);
  typedef struct packed {
    logic [3:0][31:0] word;
    logic [31:0]      rd;
  } rtdseq_mem_type;
  rtdseq_mem_type st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (rif.wr_en) begin
      nxt_st.word[rif.wr_idx] = rif.wr_data;
    end
    nxt_st.rd = st_ff.word[rif.rd_idx];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rif.rd_data = st_ff.rd;
endmodule
`default_nettype wire

// ===== verilog/rtdseq_top.sv
// Functional notes
// R1 - Time capacitor discharges alternately through sensor and reference ports.
// R2 - Single or restart opcode starts a fully autonomous sequence.
// R3 - Restart opcode runs the whole measurement twice, mains-period delay between.
// R4 - Dummy discharges on first port, then real ports one to four in order.
// R5 - Interrupt flag set only after all real port measurements finish.
// R6 - Port results go to result registers zero to three.
// R7 - Config0 bit 15 selects two or seven dummy discharges.
// R8 - Config0 bit 16 selects 128 or 512 microsecond cycle time.
// R9 - Config0 bit 17 selects two or four ports.
// R10 - Config6 bit 11 reverses port order; dummies then on port four.
// R11 - Config6 bit 15 selects 50 or 60 Hz restart base.
// R12 - Config6 bits 19:18 set restart delay 1, 1.5, 2, 2.5 periods.
// R13 - Config6 bit 30 inverts the sense stop; host sets it for comparator.
// R14 - Discharge under eight reference periods stores zero as short error.
// R15 - No stop before cycle timeout stores 0x0fffffff open error.
// R16 - Host keeps start input enabled during the whole sequence.
// R17 - Host selects 2 ms timeout when long cycle time is used; here the discharge timeout is fixed at half the cycle time.
// R18 - Host should choose the long cycle time for 150 us discharges.
// R19 - Auto oscillator control switches oscillator on and waits settling delay.
// R20 - Cycle and timeout intervals count high-speed clock ticks.
`timescale 1ns/1ps
`default_nettype none
module rtdseq_top #(
  parameter int NPORTS = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        discharge_sense_input,
  input  wire logic        start_enable,
  output var  logic        load_capacitor_pin,
  output var  logic [3:0]  resistor_port_en,
  output var  logic        fast_osc_on,
  output var  logic        int_flag
);
  rtdseq_res_if rif ();
  logic tick;

  typedef struct packed {
    rtdseq_pkg::rtdseq_state_type fsm;
    logic [31:0] cfg0;
    logic [31:0] cfg6;
    logic [7:0]  clkdiv;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        start_m;
    logic        start_s;
    logic        sense_m;
    logic        sense_s;
    logic        sense_d;
    logic [23:0] tcnt;
    logic [23:0] cap;
    logic [2:0]  dummy_left;
    logic [1:0]  step;
    logic        restart;
    logic        second;
    logic        stopped;
    logic        load;
    logic [3:0]  port_en;
    logic        osc;
    logic        intf;
    logic        busy;
    logic        wr_en;
    logic [1:0]  wr_idx;
    logic [31:0] wr_data;
  } rtdseq_top_type;

  rtdseq_top_type st_ff, nxt_st;

  rtdseq_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (st_ff.clkdiv),
    .tick    (tick)
  );

  rtdseq_resmem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif)
  );

  logic        setup_wr;
  logic        access;
  logic [2:0]  osc_mode;
  logic [23:0] cycle_tk;
  logic [23:0] settle_tk;
  logic [23:0] wait_tk;
  logic [1:0]  nports_m1;
  logic [1:0]  phys_port;
  logic        stop_seen;

  always_comb begin
    access   = psel && penable;
    setup_wr = access && pwrite && !st_ff.pready;
    osc_mode = st_ff.cfg6[rtdseq_pkg::CFG6_OSC_LSB +: 3];
    cycle_tk = st_ff.cfg0[rtdseq_pkg::CFG0_CYCLE_BIT] ? rtdseq_pkg::CYCLE_LONG_TK
                                                     : rtdseq_pkg::CYCLE_SHORT_TK;   // see R8 R20
    unique case (osc_mode)
      3'h2: settle_tk = rtdseq_pkg::SETTLE0_TK;
      3'h3: settle_tk = rtdseq_pkg::SETTLE1_TK;
      3'h4: settle_tk = rtdseq_pkg::SETTLE2_TK;
      default: settle_tk = rtdseq_pkg::SETTLE3_TK;
    endcase
    // Delay in half periods: 2, 3, 4 or 5
    wait_tk = 24'((st_ff.cfg6[rtdseq_pkg::CFG6_MAINS_BIT] ? rtdseq_pkg::HALF60_TK
                  : rtdseq_pkg::HALF50_TK)
                  * (st_ff.cfg6[rtdseq_pkg::CFG6_FACTOR_LSB +: 2] + 3'h2));   // see R11 R12
    nports_m1 = st_ff.cfg0[rtdseq_pkg::CFG0_PORTS_BIT] ? 2'h3 : 2'h1;         // see R9
    phys_port = st_ff.cfg6[rtdseq_pkg::CFG6_REVERSE_BIT] ? ~st_ff.step : st_ff.step; // see R10
    stop_seen = st_ff.sense_d ^ st_ff.cfg6[rtdseq_pkg::CFG6_INVERT_BIT];      // see R13
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_en = 1'b0;
    nxt_st.sense_m = discharge_sense_input;
    nxt_st.sense_s = st_ff.sense_m;
    nxt_st.sense_d = st_ff.sense_s;
    nxt_st.start_m = start_enable;
    nxt_st.start_s = st_ff.start_m;
    // APB slave: one wait state, reads come from registered data
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (access && !st_ff.pready) begin
      nxt_st.pready = 1'b1;
      unique case (paddr)
        rtdseq_pkg::ADDR_CFG0:   nxt_st.prdata = st_ff.cfg0;
        rtdseq_pkg::ADDR_CFG6:   nxt_st.prdata = st_ff.cfg6;
        rtdseq_pkg::ADDR_CMD:    nxt_st.prdata = 32'h0000_0000;
        rtdseq_pkg::ADDR_STATUS: nxt_st.prdata = {29'h0, st_ff.second, st_ff.busy, st_ff.intf};
        rtdseq_pkg::ADDR_CLKDIV: nxt_st.prdata = {24'h0, st_ff.clkdiv};
        rtdseq_pkg::ADDR_RES0,
        rtdseq_pkg::ADDR_RES0 + 8'h04,
        rtdseq_pkg::ADDR_RES0 + 8'h08,
        rtdseq_pkg::ADDR_RES0 + 8'h0c: nxt_st.prdata = rif.rd_data;   // see R6
        default: begin
          nxt_st.prdata  = 32'h0000_0000;
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
    // Count first so that a start or state change can clear the count
    if (tick && st_ff.tcnt != 24'hff_ffff) begin
      nxt_st.tcnt = st_ff.tcnt + 24'h1;                              // see R20
    end
    if (setup_wr) begin
      unique case (paddr)
        rtdseq_pkg::ADDR_CFG0:   nxt_st.cfg0 = pwdata;
        rtdseq_pkg::ADDR_CFG6:   nxt_st.cfg6 = pwdata;
        rtdseq_pkg::ADDR_CLKDIV: nxt_st.clkdiv = pwdata[7:0];
        rtdseq_pkg::ADDR_CMD: begin
          if (pwdata[7:0] == rtdseq_pkg::OP_CLEAR_INT) begin
            nxt_st.intf = 1'b0;
          end else if (!st_ff.busy && (pwdata[7:0] == rtdseq_pkg::OP_TEMP_SINGLE ||
                                       pwdata[7:0] == rtdseq_pkg::OP_TEMP_RESTART)) begin
            nxt_st.busy    = 1'b1;                                   // see R2
            nxt_st.restart = pwdata[0];                              // see R3
            nxt_st.second  = 1'b0;
            nxt_st.intf    = 1'b0;
            nxt_st.tcnt    = 24'h0;
            if (osc_mode >= 3'h2) begin
              nxt_st.osc = 1'b1;                                     // see R19
              nxt_st.fsm = rtdseq_pkg::ST_SETTLE;
            end else begin
              nxt_st.fsm = rtdseq_pkg::ST_CHARGE;
            end
            nxt_st.step = 2'h0;
            nxt_st.dummy_left = st_ff.cfg0[rtdseq_pkg::CFG0_DUMMY_BIT] ?
                                rtdseq_pkg::DUMMY_MANY : rtdseq_pkg::DUMMY_FEW; // see R7
          end
        end
        default: nxt_st.pslverr = 1'b1;
      endcase
    end
    unique case (st_ff.fsm)
      rtdseq_pkg::ST_IDLE: begin
        nxt_st.port_en = 4'h0;
        nxt_st.load = 1'b0;
        // Keep the oscillator request of a start taken in this cycle
        if (!nxt_st.busy) begin
          nxt_st.osc = (osc_mode == 3'h1);                           // see R19
        end
      end
      rtdseq_pkg::ST_SETTLE: begin
        if (st_ff.tcnt >= settle_tk) begin                           // see R19
          nxt_st.fsm = rtdseq_pkg::ST_CHARGE;
          nxt_st.tcnt = 24'h0;
        end
      end
      rtdseq_pkg::ST_CHARGE: begin
        // Recharge the load capacitor for half a cycle
        nxt_st.load = 1'b1;
        nxt_st.port_en = 4'h0;
        if (!st_ff.start_s) begin
          // Start withdrawn: abandon the sequence without raising the flag
          nxt_st.fsm = rtdseq_pkg::ST_IDLE;                          // see R5 R16
          nxt_st.busy = 1'b0;
          nxt_st.load = 1'b0;
        end else if (st_ff.tcnt >= (cycle_tk >> 1)) begin
          nxt_st.fsm = rtdseq_pkg::ST_DISCH;
          nxt_st.tcnt = 24'h0;
          nxt_st.stopped = 1'b0;
        end
      end
      rtdseq_pkg::ST_DISCH: begin
        nxt_st.load = 1'b0;
        nxt_st.port_en = 4'h0;
        nxt_st.port_en[phys_port] = 1'b1;                            // see R1 R4 R10
        if (stop_seen) begin
          nxt_st.cap = st_ff.tcnt;
          nxt_st.stopped = 1'b1;
          nxt_st.fsm = rtdseq_pkg::ST_STORE;
        end else if (st_ff.tcnt >= (cycle_tk >> 1)) begin
          nxt_st.fsm = rtdseq_pkg::ST_STORE;                         // see R15
        end
      end
      rtdseq_pkg::ST_STORE: begin
        nxt_st.port_en = 4'h0;
        nxt_st.tcnt = 24'h0;
        nxt_st.fsm = rtdseq_pkg::ST_CHARGE;
        if (st_ff.dummy_left != 3'h0) begin
          nxt_st.dummy_left = st_ff.dummy_left - 3'h1;               // see R4
        end else begin
          nxt_st.wr_en = 1'b1;
          nxt_st.wr_idx = st_ff.step;                                // see R6
          if (!st_ff.stopped) begin
            nxt_st.wr_data = rtdseq_pkg::RES_OPEN;                   // see R15
          end else if (st_ff.cap < rtdseq_pkg::SHORT_LIMIT_TK) begin
            nxt_st.wr_data = rtdseq_pkg::RES_SHORT;                  // see R14
          end else begin
            nxt_st.wr_data = {8'h0, st_ff.cap};
          end
          if (st_ff.step == nports_m1) begin
            nxt_st.step = 2'h0;
            if (st_ff.restart && !st_ff.second) begin
              nxt_st.fsm = rtdseq_pkg::ST_WAIT;                      // see R3
            end else begin
              nxt_st.fsm = rtdseq_pkg::ST_DONE;
            end
          end else begin
            nxt_st.step = st_ff.step + 2'h1;
          end
        end
      end
      rtdseq_pkg::ST_WAIT: begin
        nxt_st.load = 1'b0;
        if (st_ff.tcnt >= wait_tk) begin                             // see R11 R12
          nxt_st.second = 1'b1;
          nxt_st.tcnt = 24'h0;
          nxt_st.fsm = rtdseq_pkg::ST_CHARGE;
          nxt_st.dummy_left = st_ff.cfg0[rtdseq_pkg::CFG0_DUMMY_BIT] ?
                              rtdseq_pkg::DUMMY_MANY : rtdseq_pkg::DUMMY_FEW;
        end
      end
      rtdseq_pkg::ST_DONE: begin
        nxt_st.intf = 1'b1;                                          // see R5
        nxt_st.busy = 1'b0;
        nxt_st.load = 1'b0;
        nxt_st.port_en = 4'h0;
        nxt_st.fsm = rtdseq_pkg::ST_IDLE;
      end
      default: nxt_st.fsm = rtdseq_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    rif.wr_en   = st_ff.wr_en;
    rif.wr_idx  = st_ff.wr_idx;
    rif.wr_data = st_ff.wr_data;
    rif.rd_idx  = paddr[3:2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff        <= '0;
      st_ff.fsm    <= rtdseq_pkg::ST_IDLE;
      st_ff.cfg0   <= rtdseq_pkg::CFG0_RST;
      st_ff.cfg6   <= rtdseq_pkg::CFG6_RST;
      st_ff.clkdiv <= rtdseq_pkg::CLKDIV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    prdata             = st_ff.prdata;
    pready             = st_ff.pready;
    pslverr            = st_ff.pslverr;
    load_capacitor_pin = st_ff.load;
    resistor_port_en   = st_ff.port_en;
    fast_osc_on        = st_ff.osc;
    int_flag           = st_ff.intf;
  end
endmodule
`default_nettype wire

// ===== verif/rtdseq_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rtdseq_top_sva #(
  parameter int NPORTS = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  resistor_port_en,
  input wire logic        load_capacitor_pin,
  input wire logic        int_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr;
  assign clr = psel && penable && !pready && pwrite && paddr == rtdseq_pkg::ADDR_CMD
               && (pwdata[7:0] == rtdseq_pkg::OP_CLEAR_INT
               || pwdata[7:0] == rtdseq_pkg::OP_TEMP_SINGLE
               || pwdata[7:0] == rtdseq_pkg::OP_TEMP_RESTART);
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_answer_time: assert property ($rose(penable) && psel && !pready |=> pready)
    else $error("pready not one cycle after access start");
  chk_ready_access: assert property (pready |-> psel && penable && $past(psel))
    else $error("pready outside an access phase");
  chk_result_ro: assert property (pready && pwrite && paddr >= rtdseq_pkg::ADDR_RES0
    && paddr < rtdseq_pkg::ADDR_CLKDIV |-> pslverr)
    else $error("result write not refused");
  chk_port_onehot: assert property ($onehot0(resistor_port_en))
    else $error("more than one port discharging");
  chk_port_via_idle: assert property (resistor_port_en != 4'h0
    && $changed(resistor_port_en) |-> $past(resistor_port_en) == 4'h0)
    else $error("port changed without idle gap");
  chk_load_vs_port: assert property (|resistor_port_en |-> !load_capacitor_pin)
    else $error("recharge during discharge");
  chk_int_after_ports: assert property ($rose(int_flag) |-> resistor_port_en == 4'h0)
    else $error("interrupt while a port discharges");
  chk_int_sticky: assert property (int_flag && !clr |=> int_flag)
    else $error("interrupt flag dropped without clear");
  cover property ($rose(int_flag));
  cover property (pready && pslverr);
  cover property ($rose(resistor_port_en[3]));
endmodule
bind rtdseq_top rtdseq_top_sva #(.NPORTS(NPORTS)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .resistor_port_en(resistor_port_en), .load_capacitor_pin(load_capacitor_pin),
  .int_flag(int_flag));
`default_nettype wire

// ===== verif/rtdseq_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtdseq_sensor_model (
  input  wire logic             pclk,
  input  wire logic [3:0]       port_en,
  input  wire logic             load,
  input  wire logic             invert,
  input  wire logic [3:0][15:0] dly,
  output var  logic             sense
);
  logic [15:0] cnt;
  logic [1:0]  idx;
  logic [3:0]  seen[$];
  always_comb begin
    idx = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (port_en[i]) begin
        idx = 2'(i);
      end
    end
  end
  // Stop after the port's discharge time; all-ones never stops (open sensor)
  assign sense = invert ^ (port_en != 4'h0 && !load && dly[idx] != 16'hffff
                 && cnt >= dly[idx]);
  always @(posedge pclk) begin
    if (port_en != 4'h0 && cnt == 16'h0) begin
      seen.push_back(port_en);
    end
    cnt <= (port_en == 4'h0) ? 16'h0 : cnt + 16'h1;
  end
endmodule
`default_nettype wire

// ===== verif/rtd_discharge_time_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtd_discharge_time_sequencer_tb;
  typedef struct {logic [31:0] lo; logic [31:0] hi; logic err;} rtdseq_exp_type;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h0;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                sense;
  logic                start_enable = 1'b1;
  logic                load;
  logic [3:0]          port_en;
  logic                osc;
  logic                int_flag;
  logic                invert = 1'b0;
  logic [3:0][15:0]    dly = '0;
  logic [31:0]         lfsr = 32'ha551;
  int                  bad_count = 0;
  int                  cmp_count = 0;
  rtdseq_exp_type      expq[$];

  always #20 pclk = ~pclk;

  rtdseq_top #(.NPORTS(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .discharge_sense_input(sense), .start_enable(start_enable), .load_capacitor_pin(load),
    .resistor_port_en(port_en), .fast_osc_on(osc), .int_flag(int_flag));
  rtdseq_sensor_model i_part (
    .pclk(pclk), .port_en(port_en), .load(load), .invert(invert), .dly(dly), .sense(sense));

  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] lo, input logic [31:0] hi, input logic e);
    int n;
    n = 0;
    expq.push_back('{lo, hi, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, e, 1'b0);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      cmp_count++;
      if (expq.size() == 0 || pslverr !== expq[0].err || (!pwrite
          && (prdata >= expq[0].lo && prdata <= expq[0].hi) !== 1'b1)) begin
        bad_count++;
        $display("BAD apb %h expected %h seen %h", paddr, expq[0].lo, prdata);
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end

  task automatic measure(input string nm, input logic [31:0] c0, input logic [31:0] c6,
                         input logic [7:0] op, input int nd, input int np, input int runs,
                         input int mode);
    int n;
    int p;
    time t0;
    logic [15:0] d;
    n = 0;
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt_rand(lfsr);
      dly[i] <= (mode == 1 && i == 1) ? 16'h1 : (mode == 1 && i == 2) ? 16'hffff :
                (mode == 2) ? 16'h5a : 16'(32'h14 + lfsr % 32'h96);
    end
    invert <= c6[30];
    i_part.seen.delete();
    wr(rtdseq_pkg::ADDR_CFG0, c0);
    wr(rtdseq_pkg::ADDR_CFG6, c6);
    wr(rtdseq_pkg::ADDR_CMD, {24'h0, op});
    if (c6[2:0] >= 3'h2) chk("osc on", 32'h1, {31'h0, osc});
    t0 = $time;
    while (int_flag !== 1'b1 && n < 90000) begin
      @(posedge pclk);
      n++;
    end
    chk("discharge count", 32'(runs * (nd + np)), 32'(i_part.seen.size()));
    for (int k = 0; k < runs * (nd + np); k++) begin
      p = (k % (nd + np) < nd) ? 0 : k % (nd + np) - nd;
      p = c6[11] ? 3 - p : p;
      chk("port order", 32'h1 << p, {28'h0, i_part.seen[k]});
    end
    if (runs == 2) chk("restart gap", 32'h1, {31'h0, ($time - t0) >= 64'(rtdseq_pkg::HALF60_TK) * 80});
    for (int i = 0; i < np; i++) begin
      d = dly[c6[11] ? 3 - i : i];
      if (d == 16'hffff) rd(8'(rtdseq_pkg::ADDR_RES0 + 4 * i), rtdseq_pkg::RES_OPEN);
      else if (d < 16'h8) rd(8'(rtdseq_pkg::ADDR_RES0 + 4 * i), rtdseq_pkg::RES_SHORT);
      else apb(1'b0, 8'(rtdseq_pkg::ADDR_RES0 + 4 * i), 32'h0, 32'(d), 32'(d) + 32'h8, 1'b0);
    end
    wr(rtdseq_pkg::ADDR_CMD, {24'h0, rtdseq_pkg::OP_CLEAR_INT});
    rd(rtdseq_pkg::ADDR_STATUS, {29'h0, runs == 2, 2'h0});
    chk("osc off", {31'h0, c6[2:0] == 3'h1}, {31'h0, osc});
    $display("test %s done", nm);
  endtask

  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Longest path is the restart run: about 70000 cycles
  initial begin
    repeat (98000) @(posedge pclk);
    bad_count++;
    finish_test;
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(rtdseq_pkg::ADDR_CFG0, rtdseq_pkg::CFG0_RST);
    rd(rtdseq_pkg::ADDR_CFG6, rtdseq_pkg::CFG6_RST);
    rd(rtdseq_pkg::ADDR_CLKDIV, {24'h0, rtdseq_pkg::CLKDIV_RST});
    rd(rtdseq_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h24, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, rtdseq_pkg::ADDR_RES0, 32'h1, 32'h0, 32'h0, 1'b1);
    wr(rtdseq_pkg::ADDR_CFG0, 32'h0003_8000);
    rd(rtdseq_pkg::ADDR_CFG0, 32'h0003_8000);
    wr(rtdseq_pkg::ADDR_CFG6, 32'h400c_8802);
    rd(rtdseq_pkg::ADDR_CFG6, 32'h400c_8802);
    wr(rtdseq_pkg::ADDR_CLKDIV, 32'h0);
    rd(rtdseq_pkg::ADDR_CLKDIV, 32'h0);
    $display("test registers done");
    measure("faults", 32'h0002_0000, 32'h0000_0002, rtdseq_pkg::OP_TEMP_SINGLE, 2, 4, 1, 1);
    // Long cycle chosen for slow discharges; inverted stop as with the comparator
    measure("reverse", 32'h0001_8000, 32'h4000_0800, rtdseq_pkg::OP_TEMP_SINGLE, 7, 2, 1, 2);
    measure("restart", 32'h0, 32'h0000_8000, rtdseq_pkg::OP_TEMP_RESTART, 2, 2, 2, 0);
    finish_test;
  end
endmodule
`default_nettype wire
